// *** srp_defs.svh ***
`ifndef SRP_DEFS_SVH
`define SRP_DEFS_SVH
// Status byte bit positions.
`define SRP_STB_ERR_BIT      3
`define SRP_STB_MAV_BIT      4
`define SRP_STB_RQS_BIT      6
// Run-state condition bits.
`define SRP_RUN_WTG_BIT      5
`define SRP_RUN_CV_BIT       8
`define SRP_RUN_CC_BIT       10
`define SRP_RUN_PROG_BIT     14
// Signal-quality condition bits.
`define SRP_QUA_OV_BIT       0
`define SRP_QUA_OC_BIT       1
`define SRP_QUA_LEAD_BIT     2
`define SRP_QUA_TEMP_BIT     3
`define SRP_QUA_MAINS_BIT    4
`define SRP_QUA_FAN_BIT      5
// Register select codes on the status access port.
`define SRP_SEL_RUN_COND     3'h0
`define SRP_SEL_RUN_EVENT    3'h1
`define SRP_SEL_RUN_ENABLE   3'h2
`define SRP_SEL_QUA_COND     3'h3
`define SRP_SEL_QUA_EVENT    3'h4
`define SRP_SEL_QUA_ENABLE   3'h5
`define SRP_SEL_STD_EVENT    3'h6
`define SRP_SEL_SRQ_ENABLE   3'h7
// Reset values.
`define SRP_ENABLE_RST16     16'h0000
`define SRP_ENABLE_RST8      8'h00
`endif

// *** srp_event_reg.sv ***
`timescale 1ns/1ps
// One condition/event/enable triple; events latch on rising enabled bits.
module srp_event_reg #(
  parameter int W = 16
) (
  input  wire logic         clock_in,
  input  wire logic         reset_n_in,
  input  wire logic [W-1:0] cond_in,
  input  wire logic         enable_wr_in,
  input  wire logic [W-1:0] enable_data_in,
  input  wire logic         event_rd_in,
  output logic      [W-1:0] event_out,
  output logic      [W-1:0] enable_out
);
  logic [W-1:0] cond_r, cond_nxt;
  logic [W-1:0] event_r, event_nxt;
  logic [W-1:0] enable_r, enable_nxt;

  always_comb begin
    cond_nxt   = cond_in;
    enable_nxt = enable_wr_in ? enable_data_in : enable_r;
    // A read clears, but a rise in the same cycle still lands.
    event_nxt  = (event_rd_in ? '0 : event_r)
               | (cond_in & ~cond_r & enable_r);
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      cond_r   <= '0;
      event_r  <= '0;
      enable_r <= '0;
    end else begin
      cond_r   <= cond_nxt;
      event_r  <= event_nxt;
      enable_r <= enable_nxt;
    end
  end

  assign event_out  = event_r;
  assign enable_out = enable_r;
endmodule

// *** srp_host_model.sv ***
`timescale 1ns/1ps
// Host controller: sends a program message one character a cycle, or with idle gaps.
module srp_host_model
  import srp_pkg::*;
(
  input  wire logic         clock_in,
  input  wire logic         start_in,
  input  wire logic         slow_in,
  input  wire logic [4:0]   len_in,
  input  wire logic [191:0] msg_in,
  output srp_char_s         char_out,
  output logic              busy_out
);
  int i;
  initial begin
    char_out = '0;
    busy_out = 1'b0;
  end
  // The caller ends each message with a line feed.
  always begin
    @(posedge clock_in);
    if (start_in) begin
      busy_out <= 1'b1;
      for (i = len_in; i > 0; i--) begin
        char_out <= {1'b1, msg_in[8*i-1 -: 8]};
        @(posedge clock_in);
        if (slow_in) begin
          char_out <= {1'b0, ~char_out.data};
          @(posedge clock_in);
        end
      end
      // An idle line shows the inverse of the last character without gaps, and a copy of the last character with idle gaps.
      char_out <= {1'b0, ~char_out.data};
      busy_out <= 1'b0;
    end
  end
endmodule

// *** srp_parser.sv ***
`timescale 1ns/1ps
`include "srp_defs.svh"
// Classifies message units of a command stream, one character a cycle.
module srp_parser
  import srp_pkg::*;
(
  input  wire logic      clock_in,
  input  wire logic      reset_n_in,
  input  srp_char_s      char_in,
  input  wire logic      kw_short_in,
  input  wire logic      kw_long_in,
  output srp_unit_s      unit_out
);
  srp_parse_e state_r, state_nxt;
  srp_unit_s  unit_r, unit_nxt;
  logic       root_r, root_nxt;
  logic       common_r, common_nxt;
  logic       query_r, query_nxt;
  logic       kwlen_ok_r, kwlen_ok_nxt;
  logic [7:0] ch;
  logic       is_alpha;
  logic       term;

  always_comb begin
    // Fold case so mixed-case keywords match.
    ch = (char_in.data >= 8'h61 && char_in.data <= 8'h7a) ?
         (char_in.data - 8'h20) : char_in.data;
    is_alpha = (ch >= 8'h41 && ch <= 8'h5a);
    term = char_in.valid && (char_in.data == 8'h0a || char_in.data == 8'h3b);
    state_nxt    = state_r;
    root_nxt     = root_r;
    common_nxt   = common_r;
    query_nxt    = query_r;
    kwlen_ok_nxt = kwlen_ok_r;
    unit_nxt     = '0;
    if (char_in.valid) begin
      // Keyword length is judged by the matcher: short or full long form only.
      if (is_alpha) begin
        kwlen_ok_nxt = kw_short_in | kw_long_in;
      end
      case (state_r)
        SRP_P_START, SRP_P_SEP: begin
          if (ch == 8'h2a) begin
            common_nxt = 1'b1;
            state_nxt  = SRP_P_KEYWORD;
          end else if (ch == 8'h3a) begin
            root_nxt  = 1'b1;
            state_nxt = SRP_P_KEYWORD;
          end else if (is_alpha || ch == 8'h5b) begin
            state_nxt = SRP_P_KEYWORD;
          end
        end
        SRP_P_KEYWORD: begin
          if (ch == 8'h3f) begin
            query_nxt = 1'b1;
          end else if (ch == 8'h20) begin
            state_nxt = SRP_P_PARAM;
          end
        end
        SRP_P_PARAM: begin
          state_nxt = SRP_P_PARAM;
        end
        SRP_P_ERROR: begin
          state_nxt = SRP_P_ERROR;
        end
        default: begin
          state_nxt = SRP_P_START;
        end
      endcase
      if (term) begin
        unit_nxt.valid   = 1'b1;
        unit_nxt.common  = common_r;
        unit_nxt.query   = query_r;
        unit_nxt.at_root = root_r;
        unit_nxt.error   = !kwlen_ok_r || state_r == SRP_P_ERROR;
        common_nxt   = 1'b0;
        query_nxt    = 1'b0;
        kwlen_ok_nxt = 1'b1;
        // Line feed ends the message; the next unit starts at the root.
        root_nxt  = (char_in.data == 8'h0a);
        state_nxt = (char_in.data == 8'h0a) ? SRP_P_START : SRP_P_SEP;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      state_r    <= SRP_P_START;
      unit_r     <= '0;
      root_r     <= 1'b1;
      common_r   <= 1'b0;
      query_r    <= 1'b0;
      kwlen_ok_r <= 1'b1;
    end else begin
      state_r    <= state_nxt;
      unit_r     <= unit_nxt;
      root_r     <= root_nxt;
      common_r   <= common_nxt;
      query_r    <= query_nxt;
      kwlen_ok_r <= kwlen_ok_nxt;
    end
  end

  assign unit_out = unit_r;
endmodule

// *** srp_pkg.sv ***
package srp_pkg;
  typedef struct packed {
    logic wait_trigger;
    logic const_voltage;
    logic const_current;
    logic program_running;
  } srp_run_s;

  typedef struct packed {
    logic overvoltage;
    logic overcurrent;
    logic sense_lead;
    logic thermal;
    logic mains;
    logic fan;
  } srp_quality_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } srp_char_s;

  typedef struct packed {
    logic valid;
    logic common;
    logic query;
    logic at_root;
    logic error;
  } srp_unit_s;

  typedef enum logic [2:0] {
    SRP_P_START   = 3'b000,
    SRP_P_KEYWORD = 3'b001,
    SRP_P_SEP     = 3'b011,
    SRP_P_PARAM   = 3'b010,
    SRP_P_ERROR   = 3'b110
  } srp_parse_e;
endpackage

// *** srp_status.sv ***
// Contract
// - Clean decode shows zero in status bit 3.
// - Status bit 4 set while response waits.
// - Two 16-bit, two 8-bit condition registers.
// - Each has event, enable; event read clears. Code gives the 8-bit standard event register no enable.
// - Enabled rising condition bit sets event bit.
// - Any quality event sets status bit 3.
// - Request AND enable, except bit 6, into bit 6.
// - Request bit 6 drives service request line.
// - Request bit 3 set while queue nonempty.
// - Run bits 5, 14; unused bits zero.
// - Run bit 8 constant voltage, 10 constant current.
// - Quality bits 0-2: overvoltage, overcurrent, sense.
// - Quality bits 3-5: thermal, mains, fan; rest zero.
// - Asterisk means common command; question mark query.
// - After semicolon subunit, unless colon returns root.
// - Line feed ends message; message starts at root.
// - Only short or complete long keyword forms.
// - Keywords match regardless of letter case.
// - Optional keyword nodes may be omitted.
// - Analog inputs live only with strap grounded.
// - Analog mode still answers status, readback queries.
// - Relay, readbacks, trigger, inhibit always active.
// - Inhibit low turns output off.
`timescale 1ns/1ps
`include "srp_defs.svh"
module srp_status
  import srp_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  srp_run_s         run_in,
  input  srp_quality_s     quality_in,
  input  wire logic [7:0]  std_event_in,
  input  wire logic        queue_nonempty_in,
  input  wire logic        response_waiting_in,
  input  wire logic        reg_rd_in,
  input  wire logic        reg_wr_in,
  input  wire logic [2:0]  reg_sel_in,
  input  wire logic [15:0] reg_wdata_in,
  output logic      [15:0] reg_rdata_out,
  input  srp_char_s        char_in,
  input  wire logic        kw_short_in,
  input  wire logic        kw_long_in,
  output srp_unit_s        unit_out,
  output logic      [7:0]  status_byte_out,
  output logic             srq_out,
  input  wire logic        analog_strap_n_in,
  input  wire logic        analog_prog_valid_in,
  output logic             analog_remote_out,
  output logic             analog_prog_enable_out,
  output logic             digital_set_allow_out,
  input  wire logic        remote_inhibit_input,
  input  wire logic        external_trigger_input,
  output logic             external_trigger_out,
  output logic             output_enable_out,
  input  wire logic        output_on_cmd_in
);
  logic [15:0] run_cond;
  logic [15:0] qua_cond;
  logic [15:0] run_event, run_enable;
  logic [15:0] qua_event, qua_enable;
  logic [7:0]  std_ev_r, std_ev_nxt;
  logic [7:0]  srq_en_r, srq_en_nxt;
  logic [7:0]  srq_reg;
  logic [7:0]  stb_r, stb_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        strap_seen_r, strap_seen_nxt;
  logic        analog_r, analog_nxt;
  logic        oe_r, oe_nxt;
  logic        trig_r, trig_nxt;
  logic        rd_run_ev, rd_qua_ev, rd_std_ev;

  always_comb begin
    run_cond = 16'h0000;
    run_cond[`SRP_RUN_WTG_BIT]  = run_in.wait_trigger;
    run_cond[`SRP_RUN_PROG_BIT] = run_in.program_running;
    run_cond[`SRP_RUN_CV_BIT]   = run_in.const_voltage;
    run_cond[`SRP_RUN_CC_BIT]   = run_in.const_current;
    qua_cond = 16'h0000;
    qua_cond[`SRP_QUA_OV_BIT]    = quality_in.overvoltage;
    qua_cond[`SRP_QUA_OC_BIT]    = quality_in.overcurrent;
    qua_cond[`SRP_QUA_LEAD_BIT]  = quality_in.sense_lead;
    qua_cond[`SRP_QUA_TEMP_BIT]  = quality_in.thermal;
    qua_cond[`SRP_QUA_MAINS_BIT] = quality_in.mains;
    qua_cond[`SRP_QUA_FAN_BIT]   = quality_in.fan;
  end

  assign rd_run_ev = reg_rd_in && reg_sel_in == `SRP_SEL_RUN_EVENT;
  assign rd_qua_ev = reg_rd_in && reg_sel_in == `SRP_SEL_QUA_EVENT;
  assign rd_std_ev = reg_rd_in && reg_sel_in == `SRP_SEL_STD_EVENT;

  srp_event_reg #(.W(16)) u_run (
    .clock_in       (clock_in),
    .reset_n_in     (reset_n_in),
    .cond_in        (run_cond),
    .enable_wr_in   (reg_wr_in && reg_sel_in == `SRP_SEL_RUN_ENABLE),
    .enable_data_in (reg_wdata_in),
    .event_rd_in    (rd_run_ev),
    .event_out      (run_event),
    .enable_out     (run_enable)
  );

  srp_event_reg #(.W(16)) u_quality (
    .clock_in       (clock_in),
    .reset_n_in     (reset_n_in),
    .cond_in        (qua_cond),
    .enable_wr_in   (reg_wr_in && reg_sel_in == `SRP_SEL_QUA_ENABLE),
    .enable_data_in (reg_wdata_in),
    .event_rd_in    (rd_qua_ev),
    .event_out      (qua_event),
    .enable_out     (qua_enable)
  );

  srp_parser u_parser (
    .clock_in    (clock_in),
    .reset_n_in  (reset_n_in),
    .char_in     (char_in),
    .kw_short_in (kw_short_in),
    .kw_long_in  (kw_long_in),
    .unit_out    (unit_out)
  );

  // Service-request register: summary bits plus bit 6 built from the rest.
  always_comb begin
    srq_reg = 8'h00;
    srq_reg[`SRP_STB_ERR_BIT] = queue_nonempty_in | (|qua_event);
    srq_reg[`SRP_STB_MAV_BIT] = response_waiting_in;
    srq_reg[0] = |run_event;
    srq_reg[5] = |std_ev_r;
    srq_reg[`SRP_STB_RQS_BIT] = |(srq_reg & srq_en_r & 8'hbf);
  end

  always_comb begin
    // Standard events are held until read; a new event beats the clear.
    std_ev_nxt = (rd_std_ev ? 8'h00 : std_ev_r) | std_event_in;
    srq_en_nxt = (reg_wr_in && reg_sel_in == `SRP_SEL_SRQ_ENABLE) ?
                 reg_wdata_in[7:0] : srq_en_r;
    // Bit 3 is zero on clean decode and no quality event.
    stb_nxt = srq_reg;
    case (reg_sel_in)
      `SRP_SEL_RUN_COND:   rdata_nxt = run_cond;
      `SRP_SEL_RUN_EVENT:  rdata_nxt = run_event;
      `SRP_SEL_RUN_ENABLE: rdata_nxt = run_enable;
      `SRP_SEL_QUA_COND:   rdata_nxt = qua_cond;
      `SRP_SEL_QUA_EVENT:  rdata_nxt = qua_event;
      `SRP_SEL_QUA_ENABLE: rdata_nxt = qua_enable;
      `SRP_SEL_STD_EVENT:  rdata_nxt = {8'h00, std_ev_r};
      `SRP_SEL_SRQ_ENABLE: rdata_nxt = {8'h00, srq_en_r};
      default:             rdata_nxt = 16'h0000;
    endcase
    if (!reg_rd_in) begin
      rdata_nxt = rdata_r;
    end
  end

  // Strap is caught once, on the first cycle after reset release.
  always_comb begin
    strap_seen_nxt = 1'b1;
    analog_nxt     = strap_seen_r ? analog_r : !analog_strap_n_in;
    // Inhibit and trigger ignore the analog mode entirely.
    oe_nxt   = remote_inhibit_input && output_on_cmd_in;
    trig_nxt = external_trigger_input;
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      std_ev_r     <= `SRP_ENABLE_RST8;
      srq_en_r     <= `SRP_ENABLE_RST8;
      stb_r        <= 8'h00;
      rdata_r      <= 16'h0000;
      strap_seen_r <= 1'b0;
      analog_r     <= 1'b0;
      oe_r         <= 1'b0;
      trig_r       <= 1'b0;
    end else begin
      std_ev_r     <= std_ev_nxt;
      srq_en_r     <= srq_en_nxt;
      stb_r        <= stb_nxt;
      rdata_r      <= rdata_nxt;
      strap_seen_r <= strap_seen_nxt;
      analog_r     <= analog_nxt;
      oe_r         <= oe_nxt;
      trig_r       <= trig_nxt;
    end
  end

  assign status_byte_out        = stb_r;
  assign srq_out                = stb_r[`SRP_STB_RQS_BIT];
  assign reg_rdata_out          = rdata_r;
  assign analog_remote_out      = analog_r;
  assign analog_prog_enable_out = analog_r && analog_prog_valid_in;
  // Queries stay served in analog mode; only setting commands are blocked.
  assign digital_set_allow_out  = !analog_r;
  assign external_trigger_out   = trig_r;
  assign output_enable_out      = oe_r;
endmodule

// *** srp_status_monitor.sv ***
`timescale 1ns/1ps
`include "srp_defs.svh"
module srp_status_monitor
  import srp_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        reset_n_in,
  input srp_char_s        char_in,
  input srp_unit_s        unit_out,
  input wire logic        reg_rd_in,
  input wire logic [2:0]  reg_sel_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic [7:0]  status_byte_out,
  input wire logic        srq_out,
  input wire logic        response_waiting_in,
  input wire logic        queue_nonempty_in,
  input wire logic        analog_remote_out,
  input wire logic        analog_prog_valid_in,
  input wire logic        analog_prog_enable_out,
  input wire logic        digital_set_allow_out,
  input wire logic        remote_inhibit_input,
  input wire logic        output_enable_out,
  input wire logic        external_trigger_input,
  input wire logic        external_trigger_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  srq_line_a: assert property (srq_out == status_byte_out[6])
    else $error("service request line differs from status bit 6");
  srq_source_a: assert property (srq_out |-> (status_byte_out & 8'hbf) != 8'h00)
    else $error("service request without any summary bit set");
  data_ready_a: assert property ($past(reset_n_in) && $past(reset_n_in, 2) |->
    status_byte_out[4] == $past(response_waiting_in))
    else $error("status bit 4 does not follow the waiting response");
  queue_flag_a: assert property ($past(reset_n_in) && $past(queue_nonempty_in) |->
    status_byte_out[3]) else $error("status bit 3 low with queue entries");
  analog_gate_a: assert property (analog_prog_enable_out ==
    (analog_remote_out && analog_prog_valid_in)) else $error("analog inputs gated wrongly");
  digital_query_a: assert property (digital_set_allow_out == !analog_remote_out)
    else $error("digital access flag wrong");
  inhibit_off_a: assert property (!remote_inhibit_input |=> !output_enable_out)
    else $error("output on while inhibited");
  trigger_pass_a: assert property ($past(reset_n_in) && $past(reset_n_in, 2) |->
    external_trigger_out == $past(external_trigger_input)) else $error("trigger not passed");
  strap_hold_a: assert property ($past(reset_n_in) && $past(reset_n_in, 2) |->
    $stable(analog_remote_out)) else $error("analog mode changed after start-up");
  unit_cause_a: assert property (unit_out.valid |-> $past(char_in.valid) &&
    ($past(char_in.data) == 8'h3b || $past(char_in.data) == 8'h0a))
    else $error("unit emitted without separator or line end");
  run_unused_a: assert property (reg_rd_in && reg_sel_in == `SRP_SEL_RUN_COND |=>
    (reg_rdata_out & 16'hbadf) == 16'h0000) else $error("unused run bit set");
  quality_unused_a: assert property (reg_rd_in && reg_sel_in == `SRP_SEL_QUA_COND |=>
    (reg_rdata_out & 16'hffc0) == 16'h0000) else $error("unused quality bit set");
endmodule

bind srp_status srp_status_monitor srp_status_monitor_inst (.clock_in(clock_in),
  .reset_n_in(reset_n_in), .char_in(char_in), .unit_out(unit_out), .reg_rd_in(reg_rd_in),
  .reg_sel_in(reg_sel_in), .reg_rdata_out(reg_rdata_out), .status_byte_out(status_byte_out),
  .srq_out(srq_out), .response_waiting_in(response_waiting_in),
  .queue_nonempty_in(queue_nonempty_in), .analog_remote_out(analog_remote_out),
  .analog_prog_valid_in(analog_prog_valid_in), .analog_prog_enable_out(analog_prog_enable_out),
  .digital_set_allow_out(digital_set_allow_out), .remote_inhibit_input(remote_inhibit_input),
  .output_enable_out(output_enable_out), .external_trigger_input(external_trigger_input),
  .external_trigger_out(external_trigger_out));

// *** test_srp_status.sv ***
`timescale 1ns/1ps
`include "srp_defs.svh"
module test_srp_status import srp_pkg::*;;
  logic         clock_in = 1'b0;
  logic         reset_n_in = 1'b0;
  srp_run_s     run_in;
  srp_quality_s quality_in;
  srp_char_s    char_in;
  srp_unit_s    unit_out;
  srp_unit_s    units[$];
  logic [7:0]   std_event_in, status_byte_out;
  logic [2:0]   reg_sel_in;
  logic [15:0]  reg_wdata_in, reg_rdata_out;
  logic [191:0] host_msg;
  logic [4:0]   host_len;
  logic [4:0]   exp_u[7] = '{5'b11010, 5'b10110, 5'b10100, 5'b10110, 5'b10110, 5'b10011,
                             5'b10010};
  logic         queue_nonempty_in, response_waiting_in, reg_rd_in, reg_wr_in, kw_short_in;
  logic         kw_long_in, srq_out, analog_strap_n_in, analog_prog_valid_in, analog_remote_out;
  logic         analog_prog_enable_out, digital_set_allow_out, remote_inhibit_input;
  logic         external_trigger_input, external_trigger_out, output_enable_out;
  logic         output_on_cmd_in, host_start, host_slow, host_busy;
  logic [2:0]   analog_view;
  int           bad_count = 0;
  int           samples_checked = 0;

  srp_status srp_status_inst (.clock_in(clock_in), .reset_n_in(reset_n_in), .run_in(run_in),
    .quality_in(quality_in), .std_event_in(std_event_in), .queue_nonempty_in(queue_nonempty_in),
    .response_waiting_in(response_waiting_in), .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in),
    .reg_sel_in(reg_sel_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .char_in(char_in), .kw_short_in(kw_short_in), .kw_long_in(kw_long_in), .unit_out(unit_out),
    .status_byte_out(status_byte_out), .srq_out(srq_out), .analog_strap_n_in(analog_strap_n_in),
    .analog_prog_valid_in(analog_prog_valid_in), .analog_remote_out(analog_remote_out),
    .analog_prog_enable_out(analog_prog_enable_out), .digital_set_allow_out(digital_set_allow_out),
    .remote_inhibit_input(remote_inhibit_input), .external_trigger_input(external_trigger_input),
    .external_trigger_out(external_trigger_out), .output_enable_out(output_enable_out),
    .output_on_cmd_in(output_on_cmd_in));
  srp_host_model srp_host_model_inst (.clock_in(clock_in), .start_in(host_start),
    .slow_in(host_slow), .len_in(host_len), .msg_in(host_msg), .char_out(char_in),
    .busy_out(host_busy));

  assign analog_view = {analog_remote_out, analog_prog_enable_out, digital_set_allow_out};

  always #10 clock_in = ~clock_in;
  always @(posedge clock_in) if (unit_out.valid === 1'b1) units.push_back(unit_out);

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic reg_read(input logic [2:0] sel, input logic [15:0] exp);
    @(posedge clock_in);
    reg_rd_in <= 1'b1;
    reg_sel_in <= sel;
    @(posedge clock_in);
    reg_rd_in <= 1'b0;
    #1 check_val(reg_rdata_out, exp);
  endtask
  task automatic reg_write(input logic [2:0] sel, input logic [15:0] d);
    @(posedge clock_in);
    reg_wr_in <= 1'b1;
    reg_sel_in <= sel;
    reg_wdata_in <= d;
    @(posedge clock_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic send(input logic [191:0] m, input logic [4:0] n, input logic slow);
    int k;
    @(posedge clock_in);
    host_msg <= m;
    host_len <= n;
    host_slow <= slow;
    host_start <= 1'b1;
    @(posedge clock_in);
    host_start <= 1'b0;
    #1 k = 0;
    while (host_busy !== 1'b0 && k < 200) begin
      cycles(1);
      k++;
    end
    if (k == 200) bad_count++;
    cycles(3);
  endtask
  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    end_of_test();
  end

  initial begin
    run_in = '0; quality_in = '0; std_event_in = 8'h00; queue_nonempty_in = 1'b0;
    response_waiting_in = 1'b0; reg_rd_in = 1'b0; reg_wr_in = 1'b0; reg_sel_in = 3'h0;
    reg_wdata_in = 16'h0000; kw_short_in = 1'b1; kw_long_in = 1'b0; analog_strap_n_in = 1'b1;
    analog_prog_valid_in = 1'b1; remote_inhibit_input = 1'b1; external_trigger_input = 1'b0;
    output_on_cmd_in = 1'b1; host_start = 1'b0; host_slow = 1'b0; host_msg = '0; host_len = 5'h00;
    cycles(16);
    @(posedge clock_in) reset_n_in <= 1'b1;
    reg_read(`SRP_SEL_RUN_ENABLE, `SRP_ENABLE_RST16);
    reg_read(`SRP_SEL_QUA_ENABLE, `SRP_ENABLE_RST16);
    reg_read(`SRP_SEL_SRQ_ENABLE, {8'h00, `SRP_ENABLE_RST8});
    check_val({13'h0000, analog_view}, 16'h0001);
    @(posedge clock_in) run_in <= '1;
    @(posedge clock_in) quality_in <= '1;
    reg_read(`SRP_SEL_RUN_COND, 16'h4520);
    reg_read(`SRP_SEL_QUA_COND, 16'h003f);
    reg_read(`SRP_SEL_QUA_EVENT, 16'h0000);
    @(posedge clock_in) quality_in <= '0;
    reg_write(`SRP_SEL_QUA_ENABLE, 16'h0001);
    @(posedge clock_in) quality_in <= '1;
    @(posedge clock_in) quality_in <= '0;
    cycles(2);
    check_val({8'h00, status_byte_out} & 16'h0008, 16'h0008);
    reg_read(`SRP_SEL_QUA_EVENT, 16'h0001);
    reg_read(`SRP_SEL_QUA_EVENT, 16'h0000);
    cycles(2);
    check_val({8'h00, status_byte_out} & 16'h0008, 16'h0000);
    reg_write(`SRP_SEL_RUN_ENABLE, 16'h0020);
    @(posedge clock_in) run_in <= '0;
    @(posedge clock_in) run_in <= '1;
    cycles(2);
    check_val({8'h00, status_byte_out} & 16'h0001, 16'h0001);
    reg_read(`SRP_SEL_RUN_EVENT, 16'h0020);
    @(posedge clock_in) std_event_in <= 8'h04;
    @(posedge clock_in) std_event_in <= 8'h00;
    reg_read(`SRP_SEL_STD_EVENT, 16'h0004);
    reg_write(`SRP_SEL_SRQ_ENABLE, 16'h0018);
    @(posedge clock_in) queue_nonempty_in <= 1'b1;
    @(posedge clock_in) response_waiting_in <= 1'b1;
    cycles(3);
    check_val({8'h00, status_byte_out}, 16'h0058);
    check_val({15'h0000, srq_out}, 16'h0001);
    @(posedge clock_in) queue_nonempty_in <= 1'b0;
    @(posedge clock_in) response_waiting_in <= 1'b0;
    cycles(3);
    check_val({15'h0000, srq_out}, 16'h0000);
    @(posedge clock_in) remote_inhibit_input <= 1'b0;
    @(posedge clock_in) external_trigger_input <= 1'b1;
    cycles(2);
    check_val({15'h0000, output_enable_out}, 16'h0000);
    check_val({15'h0000, external_trigger_out}, 16'h0001);
    @(posedge clock_in) remote_inhibit_input <= 1'b1;
    cycles(2);
    check_val({15'h0000, output_enable_out}, 16'h0001);
    send("*RST\nA?;B?;:C?\nvOlT?\n", 5'd21, 1'b0);
    @(posedge clock_in) kw_short_in <= 1'b0;
    send("X\n", 5'd2, 1'b1);
    @(posedge clock_in) kw_long_in <= 1'b1;
    send("Y\n", 5'd2, 1'b0);
    check_val(16'(units.size()), 16'h0007);
    foreach (exp_u[i]) check_val(units[i], exp_u[i]);
    @(posedge clock_in) reset_n_in <= 1'b0;
    @(posedge clock_in) analog_strap_n_in <= 1'b0;
    cycles(2);
    @(posedge clock_in) reset_n_in <= 1'b1;
    cycles(2);
    check_val({15'h0000, analog_prog_enable_out}, 16'h0001);
    check_val({13'h0000, analog_view}, 16'h0006);
    reg_read(`SRP_SEL_RUN_COND, 16'h4520);
    end_of_test();
  end
endmodule
